/* ksc_timing.sv */
// Purpose: Debounce, interrupt, autorepeat and autosleep timing control.
// Assumes: Register port, key-event and queue inputs share mclk.
// Notes:   The serial engine, key queue and scanner live elsewhere.
`timescale 1ns/1ps
`default_nettype none
module ksc_timing
    import ksc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = KSC_TICK_CYCLES
) (
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire ksc_req_t   req,
    output var  logic [7:0] rdata,
    input  wire logic       key_event,
    input  wire logic       key_held,
    input  wire logic [4:0] fifo_count,
    input  wire logic       fifo_read,
    input  wire logic       int_clear_on_read,
    output var  logic       int_n,
    output var  logic       dbn_tick,
    output var  logic [5:0] press_ms,
    output var  logic [5:0] release_ms,
    output var  logic       repeat_push,
    output var  logic       repeat_more,
    output var  logic       sleep_mode
);

    // Milliseconds for a four-bit debounce code.
    function automatic logic [5:0] dbn_ms(input logic [3:0] code);
        dbn_ms = 6'(KSC_DBN_MS_STEP * (int'(code) + 1));
    endfunction

    // Milliseconds for a sleep code; zero means disabled.
    function automatic logic [13:0] sleep_ms(input logic [2:0] code);
        if (code == 3'h0) begin
            sleep_ms = 14'h0000;
        end else if (code == 3'h7) begin
            sleep_ms = 14'(KSC_SLEEP_MAX_MS >> 5);
        end else begin
            sleep_ms = 14'(KSC_SLEEP_MAX_MS >> (int'(code) - 1));
        end
    endfunction

    logic        ms_tick;      // One-cycle millisecond enable.
    logic [7:0]  dbn_reg_q;    // Debounce times register.
    logic [7:0]  dbn_reg_d;
    logic [7:0]  int_reg_q;    // Interrupt policy register.
    logic [7:0]  int_reg_d;
    logic [7:0]  rpt_reg_q;    // Repeat control register.
    logic [7:0]  rpt_reg_d;
    logic [2:0]  slp_reg_q;    // Idle sleep timeout code.
    logic [2:0]  slp_reg_d;
    logic [7:0]  rdata_d;
    logic [5:0]  dbn_cnt_q;    // Milliseconds into a debounce cycle.
    logic [5:0]  dbn_cnt_d;
    logic        dbn_tick_d;
    logic [5:0]  press_ms_d;
    logic [5:0]  release_ms_d;
    logic [4:0]  int_cnt_q;    // Debounce cycles since last time hit.
    logic [4:0]  int_cnt_d;
    logic        int_n_d;
    ksc_rpt_state_t rpt_st_q;  // Autorepeat sequencer state.
    ksc_rpt_state_t rpt_st_d;
    logic [7:0]  rpt_cnt_q;    // Debounce cycles toward next repeat.
    logic [7:0]  rpt_cnt_d;
    logic        repeat_push_d;
    logic        repeat_more_d;
    logic [13:0] idle_cnt_q;   // Milliseconds without a key event.
    logic [13:0] idle_cnt_d;
    logic        sleep_mode_d;

    // The only time base: dbn_cnt_q and idle_cnt_q advance on this enable, int_cnt_q and rpt_cnt_q on dbn_tick.
    ksc_tick_div #(
        .DIV (TICK_CYCLES)
    ) u_tick (
        .mclk  (mclk),
        .reset (reset),
        .tick  (ms_tick)
    );

    // Register writes and reads; unmapped offsets read as zero.
    always_comb begin
        dbn_reg_d = dbn_reg_q;
        int_reg_d = int_reg_q;
        rpt_reg_d = rpt_reg_q;
        slp_reg_d = slp_reg_q;
        rdata_d   = rdata;
        if (req.wr) begin
            case (req.addr)
                KSC_OFF_DEBOUNCE: dbn_reg_d = req.wdata;
                KSC_OFF_INTPOL:   int_reg_d = req.wdata;
                KSC_OFF_REPEAT:   rpt_reg_d = req.wdata;
                KSC_OFF_SLEEP:    slp_reg_d = req.wdata[2:0];
                default:          dbn_reg_d = dbn_reg_q;
            endcase
        end
        if (req.rd) begin
            case (req.addr)
                KSC_OFF_DEBOUNCE: rdata_d = dbn_reg_q;
                KSC_OFF_INTPOL:   rdata_d = int_reg_q;
                KSC_OFF_REPEAT:   rdata_d = rpt_reg_q;
                KSC_OFF_SLEEP:    rdata_d = {5'h00, slp_reg_q};
                default:          rdata_d = 8'h00;
            endcase
        end
    end

    // Debounce cycle timer and decoded debounce times.
    always_comb begin
        press_ms_d   = dbn_ms(dbn_reg_q[KSC_DBN_PRESS_LSB +: 4]);
        release_ms_d = dbn_ms(dbn_reg_q[KSC_DBN_RELEASE_LSB +: 4]);
        dbn_cnt_d    = dbn_cnt_q;
        dbn_tick_d   = 1'b0;
        if (ms_tick) begin
            // A cycle lasts the press debounce time.
            if (dbn_cnt_q + 6'h01 >= press_ms) begin
                dbn_cnt_d  = 6'h00;
                dbn_tick_d = 1'b1;
            end else begin
                dbn_cnt_d = dbn_cnt_q + 6'h01;
            end
        end
    end

    // Interrupt sources; a new cause wins over a clear in the same cycle.
    always_comb begin
        logic [4:0] time_n;
        logic [2:0] lvl_n;
        logic       time_hit;
        logic       lvl_hit;
        logic       clr;
        time_n    = int_reg_q[KSC_INT_TIME_LSB +: 5];
        lvl_n     = int_reg_q[KSC_INT_LEVEL_LSB +: 3];
        time_hit  = 1'b0;
        int_cnt_d = int_cnt_q;
        if (time_n == 5'h00) begin
            int_cnt_d = 5'h00;
        end else if (dbn_tick) begin
            if (int_cnt_q + 5'h01 >= time_n) begin
                int_cnt_d = 5'h00;
                time_hit  = 1'b1;
            end else begin
                int_cnt_d = int_cnt_q + 5'h01;
            end
        end
        lvl_hit = (lvl_n != 3'h0) && (fifo_count >= {1'b0, lvl_n, 1'b0});
        clr = int_clear_on_read ? fifo_read : (fifo_count == 5'h00);
        if (time_hit || lvl_hit) begin
            int_n_d = 1'b0;
        end else if (clr) begin
            int_n_d = 1'b1;
        end else begin
            int_n_d = int_n;
        end
    end

    // Autorepeat sequencer, counting debounce cycles while a key is held.
    always_comb begin
        logic [7:0] delay_c;
        logic [7:0] rate_c;
        delay_c = 8'(KSC_RPT_DELAY_STEP *
                     (int'(rpt_reg_q[KSC_RPT_DELAY_LSB +: 4]) + 1));
        rate_c  = 8'(KSC_RPT_RATE_STEP *
                     (int'(rpt_reg_q[KSC_RPT_RATE_LSB +: 3]) + 1));
        rpt_st_d      = rpt_st_q;
        rpt_cnt_d     = rpt_cnt_q;
        repeat_push_d = 1'b0;
        repeat_more_d = repeat_more;
        if (!rpt_reg_q[KSC_RPT_ENABLE_BIT] || !key_held || key_event) begin
            // Disabled, released, or a new key: start over.
            rpt_st_d  = KSC_RPT_IDLE;
            rpt_cnt_d = 8'h00;
        end else begin
            case (rpt_st_q)
                KSC_RPT_IDLE: begin
                    rpt_st_d  = KSC_RPT_DELAY;
                    rpt_cnt_d = 8'h00;
                end
                KSC_RPT_DELAY, KSC_RPT_RATE: begin
                    if (dbn_tick) begin
                        if (rpt_cnt_q + 8'h01 >=
                            ((rpt_st_q == KSC_RPT_DELAY) ? delay_c : rate_c)) begin
                            rpt_cnt_d     = 8'h00;
                            rpt_st_d      = KSC_RPT_RATE;
                            repeat_push_d = 1'b1;
                            repeat_more_d = (fifo_count != 5'h00);
                        end else begin
                            rpt_cnt_d = rpt_cnt_q + 8'h01;
                        end
                    end
                end
                default: begin
                    rpt_st_d = KSC_RPT_IDLE;
                end
            endcase
        end
    end

    // Inactivity timer; a key event restarts it and wakes the block.
    always_comb begin
        logic [13:0] limit;
        limit        = sleep_ms(slp_reg_q);
        idle_cnt_d   = idle_cnt_q;
        sleep_mode_d = sleep_mode;
        if (key_event) begin
            idle_cnt_d   = 14'h0000;
            sleep_mode_d = 1'b0;
        end else if (limit == 14'h0000) begin
            idle_cnt_d = 14'h0000;
        end else if (ms_tick && !sleep_mode) begin
            if (idle_cnt_q + 14'h0001 >= limit) begin
                idle_cnt_d   = 14'h0000;
                sleep_mode_d = 1'b1;
            end else begin
                idle_cnt_d = idle_cnt_q + 14'h0001;
            end
        end
    end

    // Registers all state; every output comes from here.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            dbn_reg_q   <= KSC_RST_DEBOUNCE;
            int_reg_q   <= KSC_RST_INTPOL;
            rpt_reg_q   <= KSC_RST_REPEAT;
            slp_reg_q   <= KSC_RST_SLEEP;
            rdata       <= 8'h00;
            dbn_cnt_q   <= 6'h00;
            dbn_tick    <= 1'b0;
            press_ms    <= 6'h20;
            release_ms  <= 6'h20;
            int_cnt_q   <= 5'h00;
            int_n       <= 1'b1;
            rpt_st_q    <= KSC_RPT_IDLE;
            rpt_cnt_q   <= 8'h00;
            repeat_push <= 1'b0;
            repeat_more <= 1'b0;
            idle_cnt_q  <= 14'h0000;
            sleep_mode  <= 1'b0;
        end else begin
            dbn_reg_q   <= dbn_reg_d;
            int_reg_q   <= int_reg_d;
            rpt_reg_q   <= rpt_reg_d;
            slp_reg_q   <= slp_reg_d;
            rdata       <= rdata_d;
            dbn_cnt_q   <= dbn_cnt_d;
            dbn_tick    <= dbn_tick_d;
            press_ms    <= press_ms_d;
            release_ms  <= release_ms_d;
            int_cnt_q   <= int_cnt_d;
            int_n       <= int_n_d;
            rpt_st_q    <= rpt_st_d;
            rpt_cnt_q   <= rpt_cnt_d;
            repeat_push <= repeat_push_d;
            repeat_more <= repeat_more_d;
            idle_cnt_q  <= idle_cnt_d;
            sleep_mode  <= sleep_mode_d;
        end
    end

endmodule
`default_nettype wire

/* ksc_pkg.sv */
// Purpose: Shared constants and types for the key-scan timing block.
// Assumes: A 20 MHz system clock and byte-wide registers.
// Notes:   Every offset, field position, reset value and timing count.
package ksc_pkg;

    // Register offsets on the serial register port.
    localparam logic [7:0] KSC_OFF_DEBOUNCE = 8'h02;
    localparam logic [7:0] KSC_OFF_INTPOL   = 8'h03;
    localparam logic [7:0] KSC_OFF_REPEAT   = 8'h05;
    localparam logic [7:0] KSC_OFF_SLEEP    = 8'h06;

    // Reset values of the four registers.
    localparam logic [7:0] KSC_RST_DEBOUNCE = 8'hFF;
    localparam logic [7:0] KSC_RST_INTPOL   = 8'h00;
    localparam logic [7:0] KSC_RST_REPEAT   = 8'h00;
    localparam logic [2:0] KSC_RST_SLEEP    = 3'h7;

    // Field positions.
    localparam int KSC_DBN_PRESS_LSB   = 0;
    localparam int KSC_DBN_RELEASE_LSB = 4;
    localparam int KSC_INT_TIME_LSB    = 0;
    localparam int KSC_INT_LEVEL_LSB   = 5;
    localparam int KSC_RPT_DELAY_LSB   = 0;
    localparam int KSC_RPT_RATE_LSB    = 4;
    localparam int KSC_RPT_ENABLE_BIT  = 7;

    // Scale factors of the coded fields.
    localparam int KSC_DBN_MS_STEP     = 2;
    localparam int KSC_RPT_DELAY_STEP  = 8;
    localparam int KSC_RPT_RATE_STEP   = 4;
    localparam int KSC_SLEEP_MAX_MS    = 8192;

    // Time base: one millisecond tick derived from the clock.
    localparam int KSC_CLK_PERIOD_NS   = 50;
    localparam int KSC_TICK_PERIOD_NS  = 1000000;
    localparam int KSC_TICK_CYCLES     =
        KSC_TICK_PERIOD_NS / KSC_CLK_PERIOD_NS;

    // One access from the serial bus engine.
    typedef struct packed {
        logic       wr;     // One-cycle write strobe.
        logic       rd;     // One-cycle read strobe.
        logic [7:0] addr;   // Register offset.
        logic [7:0] wdata;  // Write data.
    } ksc_req_t;

    // States of the autorepeat sequencer.
    typedef enum logic [1:0] {
        KSC_RPT_IDLE,
        KSC_RPT_DELAY,
        KSC_RPT_RATE
    } ksc_rpt_state_t;

endpackage

/* ksc_tick_div.sv */
// Purpose: Divides the clock down to a one-cycle millisecond enable.
// Assumes: Free-running clock; the divider never depends on bus traffic.
// Notes:   DIV may be shortened in simulation.
`timescale 1ns/1ps
`default_nettype none
module ksc_tick_div #(
    parameter int unsigned DIV = 20000
) (
    input  wire logic mclk,
    input  wire logic reset,
    output var  logic tick
);

    logic [15:0] cnt_q;  // Cycles since the last tick.
    logic [15:0] cnt_d;  // Next count.
    logic        tick_d; // Next tick value.

    // The count wraps after DIV cycles and raises the tick for one cycle.
    always_comb begin
        if (cnt_q == 16'(DIV - 1)) begin
            cnt_d  = 16'h0000;
            tick_d = 1'b1;
        end else begin
            cnt_d  = cnt_q + 16'h0001;
            tick_d = 1'b0;
        end
    end

    // Registers the divider state.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_q <= 16'h0000;
            tick  <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick  <= tick_d;
        end
    end

endmodule
`default_nettype wire

/* ksc_queue_model.sv */
// Purpose: Behavioural key queue that reports its occupancy back.
// Assumes: At most one push and one host read per clock.
// Notes:   Saturates at sixteen entries and never goes below zero.
`timescale 1ns/1ps
`default_nettype none
module ksc_queue_model (
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic       push,
    input  wire logic       pop,
    output var  logic [4:0] count
);
    // Occupancy follows key entries, repeat entries and host reads.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            count <= 5'h00;
        end else if (push && !pop && count != 5'h10) begin
            count <= count + 5'h01;
        end else if (pop && !push && count != 5'h00) begin
            count <= count - 5'h01;
        end
    end
endmodule
`default_nettype wire

/* ksc_timing_properties.sv */
// Purpose: Port-level timing checks for the key-scan timing block.
// Assumes: One mclk domain; register writes are seen on req.
// Notes:   Mirrors track the policy and repeat-enable registers.
`timescale 1ns/1ps
`default_nettype none
module ksc_timing_properties
    import ksc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = 4
) (
    input wire logic       mclk,
    input wire logic       reset,
    input wire ksc_req_t   req,
    input wire logic [7:0] rdata,
    input wire logic       key_event,
    input wire logic       key_held,
    input wire logic [4:0] fifo_count,
    input wire logic       fifo_read,
    input wire logic       int_clear_on_read,
    input wire logic       int_n,
    input wire logic       dbn_tick,
    input wire logic [5:0] press_ms,
    input wire logic [5:0] release_ms,
    input wire logic       repeat_push,
    input wire logic       repeat_more,
    input wire logic       sleep_mode
);
    logic [7:0] pol_q; // Mirror of the interrupt policy register.
    logic       rpt_q; // Mirror of the repeat enable bit.
    logic       lvl;   // The queue level cause is present.
    // Mirror the registers that the checks depend on.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pol_q <= 8'h00;
            rpt_q <= 1'b0;
        end else if (req.wr && req.addr == KSC_OFF_INTPOL) begin
            pol_q <= req.wdata;
        end else if (req.wr && req.addr == KSC_OFF_REPEAT) begin
            rpt_q <= req.wdata[7];
        end
    end
    assign lvl = pol_q[7:5] != 3'h0 &&
                 fifo_count >= {1'b0, pol_q[7:5], 1'b0};
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // A debounce cycle spans at least four clocks.
    sequence s_no_tick;
        !dbn_tick [*3];
    endsequence
    AST_RST: assert property ($fell(reset) |-> int_n && !sleep_mode
        && press_ms == 6'h20 && release_ms == 6'h20) else $error("reset");
    AST_PRESS: assert property (req.wr && req.addr == 8'h02 |-> ##2
        press_ms == {$past(req.wdata[3:0], 2) + 5'h01, 1'b0})
        else $error("press time wrong");
    AST_TIME: assert property (pol_q[4:0] == 5'h01 && dbn_tick |=>
        !int_n) else $error("time interrupt missing");
    AST_LEVEL: assert property (lvl |=> !int_n)
        else $error("level interrupt missing");
    AST_EMPTY: assert property (!int_clear_on_read && !dbn_tick &&
        fifo_count == 5'h00 |=> int_n) else $error("empty clear missing");
    AST_RPT_OFF: assert property (!rpt_q && !$past(rpt_q) |->
        !repeat_push) else $error("repeat while disabled");
    AST_MORE: assert property (repeat_push |->
        repeat_more == ($past(fifo_count) != 5'h00)) else $error("more flag");
    AST_DBN_GAP: assert property (dbn_tick |=> s_no_tick)
        else $error("debounce cycle too short");
    AST_WAKE: assert property (key_event |=> !sleep_mode)
        else $error("key event did not wake");
endmodule
bind ksc_timing ksc_timing_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
    .mclk(mclk), .reset(reset), .req(req), .rdata(rdata),
    .key_event(key_event), .key_held(key_held), .fifo_count(fifo_count),
    .fifo_read(fifo_read), .int_clear_on_read(int_clear_on_read),
    .int_n(int_n), .dbn_tick(dbn_tick), .press_ms(press_ms),
    .release_ms(release_ms), .repeat_push(repeat_push),
    .repeat_more(repeat_more), .sleep_mode(sleep_mode));
`default_nettype wire

/* keyscan_timing_config_test.sv */
// Purpose: Self-checking bench for the key-scan timing block.
// Assumes: TICK_CYCLES of 4, so one millisecond is four clocks.
// Notes:   Inputs move on the falling edge; a queue model answers.
`timescale 1ns/1ps
`default_nettype none
module keyscan_timing_config_test import ksc_pkg::*;;
    localparam int T = 4; // Clocks per millisecond tick.
    ksc_req_t   req;
    logic       mclk, reset, key_event, key_held, fifo_read, clr_rd;
    logic       int_n, dbn_tick, repeat_push, repeat_more, sleep_mode;
    logic [7:0] rdata, v, w;
    logic [7:0] offs [5] = '{8'h02, 8'h03, 8'h05, 8'h06, 8'h04};
    logic [7:0] rstv [4] = '{8'hFF, 8'h00, 8'h00, 8'h07};
    logic [7:0] code [4] = '{8'h5A, 8'hFF, 8'h31, 8'h00};
    logic [5:0] press_ms, release_ms;
    logic [4:0] fifo_count;
    int         errors, check_count, c, t, n;
    ksc_timing #(.TICK_CYCLES(T)) u_dut (.mclk(mclk), .reset(reset),
        .req(req), .rdata(rdata), .key_event(key_event),
        .key_held(key_held), .fifo_count(fifo_count),
        .fifo_read(fifo_read), .int_clear_on_read(clr_rd),
        .int_n(int_n), .dbn_tick(dbn_tick), .press_ms(press_ms),
        .release_ms(release_ms), .repeat_push(repeat_push),
        .repeat_more(repeat_more), .sleep_mode(sleep_mode));
    ksc_queue_model u_queue (.mclk(mclk), .reset(reset),
        .push(key_event | repeat_push), .pop(fifo_read), .count(fifo_count));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Prints the verdict and ends the run.
    task automatic give_verdict();
        if (errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(negedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{1'b1, 1'b0, a, d};
        step(1);
        req = '0;
        step(2);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        req = '{1'b0, 1'b1, a, 8'h00};
        step(1);
        req = '0;
        step(1);
        d = rdata;
    endtask
    // One-clock pulse on the queue read or on the key event input.
    task automatic pulse(input bit host_rd);
        fifo_read = host_rd;
        key_event = !host_rd;
        step(1);
        fifo_read = 1'b0;
        key_event = 1'b0;
        step(1);
    endtask
    // Reserved sleep bits read zero and unmapped places read zero.
    function automatic logic [7:0] exp_rd(input logic [7:0] a, d);
        return (a == 8'h06) ? (d & 8'h07) : (a == 8'h04) ? 8'h00 : d;
    endfunction
    // Bounded wait; counts clocks and debounce ticks on the way.
    task automatic wait_sig(input int s, input int lim);
        c = 0;
        t = 0;
        while ((s == 0 ? !int_n : s == 1 ? sleep_mode :
                s == 2 ? dbn_tick : repeat_push) !== 1'b1) begin
            step(1);
            c++;
            t += (dbn_tick === 1'b1);
            if (c > lim) begin
                errors++;
                $display("[ERR] %0t got %h exp %h", $time, c, lim);
                give_verdict();
            end
        end
    endtask
    initial begin
        void'($urandom(32'h80e7_e885));
        {reset, key_event, key_held, fifo_read, clr_rd} = 5'h10;
        req = '0;
        errors = 0;
        check_count = 0;
        step(6);
        reset = 1'b0;
        for (int i = 0; i < 4; i++) begin
            rd(offs[i], v);
            chk(v, rstv[i]);
        end
        for (int i = 0; i < 12; i++) begin
            n = $urandom % 5;
            w = 8'($urandom);
            wr(offs[n], w);
            rd(offs[n], v);
            chk(v, exp_rd(offs[n], w));
        end
        wr(8'h03, 8'h00);
        wr(8'h06, 8'h00);
        code[0] = 8'($urandom);
        foreach (code[j]) begin
            wr(8'h02, code[j]);
            chk({2'b00, press_ms}, 8'((code[j][3:0] + 1) * 2));
            chk({2'b00, release_ms}, 8'((code[j][7:4] + 1) * 2));
            wait_sig(2, 400);
            step(1);
            wait_sig(2, 400);
            chk(8'(c + 1), 8'((code[j][3:0] + 1) * 2 * T));
        end
        clr_rd = 1'b1;
        wr(8'h03, 8'h21);
        wait_sig(0, 12);
        wr(8'h03, 8'h00);
        pulse(1'b1);
        step(40);
        chk({7'h00, int_n}, 8'h01);
        clr_rd = 1'b0;
        for (int i = 1; i < 8; i++) begin
            wr(8'h03, 8'(i << 5));
            repeat (2 * i - 1) pulse(1'b0);
            step(1);
            chk({7'h00, int_n}, 8'h01);
            pulse(1'b0);
            chk({7'h00, int_n}, 8'h00);
            repeat (2 * i) pulse(1'b1);
            step(1);
            chk({7'h00, int_n}, 8'h01);
        end
        // Time interrupt period above one, queue empty so it pulses.
        n = $urandom % 30 + 2;
        wr(8'h03, 8'(n));
        wait_sig(0, 600);
        step(1);
        wait_sig(0, 600);
        chk(8'(t), 8'(n));
        wr(8'h03, 8'h00);
        wr(8'h05, 8'h7F);
        key_held = 1'b1;
        n = 0;
        repeat (200) begin
            step(1);
            n += (repeat_push === 1'b1);
        end
        chk(8'(n), 8'h00);
        code[0] = 8'($urandom) | 8'h80;
        code[1] = 8'h80;
        code[2] = 8'hF1;
        code[3] = 8'hFF;
        foreach (code[j]) begin
            key_held = 1'b0;
            wr(8'h05, code[j]);
            key_held = code[j][7];
            wait_sig(3, 2000);
            chk(8'(t), 8'((code[j][3:0] + 1) * 8));
            chk({7'h00, repeat_more}, {7'h00, fifo_count != 5'h00});
            step(1);
            wait_sig(3, 2000);
            chk(8'(t), 8'((code[j][6:4] + 1) * 4));
            chk({7'h00, repeat_more}, {7'h00, fifo_count != 5'h00});
        end
        key_held = 1'b0;
        wr(8'h06, 8'h06);
        pulse(1'b0);
        step(1000);
        chk({7'h00, sleep_mode}, 8'h00);
        wait_sig(1, 100);
        pulse(1'b0);
        chk({7'h00, sleep_mode}, 8'h00);
        wr(8'h06, 8'h00);
        step(1200);
        chk({7'h00, sleep_mode}, 8'h00);
        give_verdict();
    end
endmodule
`default_nettype wire
